// *** design/hphp_params.svh ***
// Timing and code constants for the host primitive handshake port.
// Assumes inclusion by bare name from the design files.
`ifndef HPHP_PARAMS_SVH
`define HPHP_PARAMS_SVH
`define HPHP_PRIM_BYTES 10
`define HPHP_ERR_HEADER 8'h99
`define HPHP_ERR_TASK_QUEUE 8'h00
`define HPHP_ERR_MEM_UNDERRUN 8'h02
`define HPHP_ERR_NET_QUEUE 8'h05
`define HPHP_ERR_LINE_UNDERRUN 8'h06
`define HPHP_ERR_SERIAL_BUS 8'h0b
`define HPHP_ERR_FILL 8'h00
`define HPHP_STROBE_NS 50
`define HPHP_CLK_NS 25
`define HPHP_STROBE_CYC ((`HPHP_STROBE_NS + `HPHP_CLK_NS - 1) / `HPHP_CLK_NS)
`define HPHP_FIFO_DEPTH 8
`endif

// *** design/hphp_pkg.sv ***
// Types shared by the device end and the bench of the host primitive handshake port.
// Assumes hphp_params.svh is compiled alongside.
package hphp_pkg;
    typedef enum logic [2:0] {
        FAULT_TASK_QUEUE,
        FAULT_MEM_UNDERRUN,
        FAULT_NET_QUEUE,
        FAULT_LINE_UNDERRUN,
        FAULT_SERIAL_BUS
    } hphp_fault_t;
endpackage

// *** design/hphp_if.sv ***
// Four-line handshake plus two byte paths between host and device.
// Assumes the testbench drives clk and nrst.
`timescale 1ns/1ps
interface hphp_if;
    logic host_write_strobe;
    logic device_write_ack;
    logic byte_avail_to_host;
    logic host_read_ack;
    logic device_reset;
    logic latch_write;
    logic [7:0] latch_data;
    logic [7:0] inbound_data_port;
    logic [7:0] outbound_data_port;
    logic out_buf_oe;
    logic [7:0] host_bus;
    assign host_bus = out_buf_oe ? outbound_data_port : 8'h00;
    modport device (
        input host_write_strobe, host_read_ack, device_reset, latch_write,
        input inbound_data_port,
        output device_write_ack, byte_avail_to_host, outbound_data_port
    );
    modport host (
        output host_write_strobe, host_read_ack, device_reset, latch_write,
        output latch_data, out_buf_oe,
        input device_write_ack, byte_avail_to_host, host_bus
    );
    // Inbound latch glue: the port follows latch_data directly; latch_write is not used here.
    assign inbound_data_port = latch_data;
endinterface

// *** design/hphp_fifo.sv ***
// Flip-flop FIFO with valid and ready on both sides.
// Assumes a single clock and active-low asynchronous reset.
`timescale 1ns/1ps
module hphp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Fill side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [AW:0] cnt;
    } hphp_fifo_st_t;
    hphp_fifo_st_t st_ff, nxt_st;
    logic push, pop;
    assign in_ready = st_ff.cnt != (AW+1)'(DEPTH);
    assign out_valid = st_ff.cnt != '0;
    assign out_data = st_ff.mem[st_ff.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.mem[st_ff.wr] = in_data;
            nxt_st.wr = (st_ff.wr == AW'(DEPTH-1)) ? '0 : st_ff.wr + 1'b1;
        end
        if (pop) begin
            nxt_st.rd = (st_ff.rd == AW'(DEPTH-1)) ? '0 : st_ff.rd + 1'b1;
        end
        nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule

// *** design/hphp_device.sv ***
// Device end of the host primitive handshake port.
// Assumes the host keeps the handshake; codec commands pass as primitives.
`timescale 1ns/1ps
`include "hphp_params.svh"
module hphp_device #(
    parameter int DEPTH = `HPHP_FIFO_DEPTH
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Link to host glue.
    hphp_if.device link,
    // Inbound command bytes to firmware.
    output logic [7:0] cmd_byte,
    output logic cmd_valid,
    output logic cmd_last,
    // Outbound indication bytes from firmware.
    input wire logic [7:0] ind_byte,
    input wire logic ind_valid,
    output logic ind_ready,
    // Fault report.
    input wire logic fault_valid,
    input wire hphp_pkg::hphp_fault_t fault_code,
    output logic halted
);
    // ==========================================================
    // State
    typedef struct packed {
        // Start-up pulse and write-ack flag.
        logic rst_seen;
        logic ack_pend;
        logic ack_q;
        logic wack;
        // Sampled host lines and the outbound byte on offer.
        logic strobe_q;
        logic rack_q;
        logic avail;
        logic [7:0] obyte;
        // Inbound bytes handed to firmware.
        logic [3:0] icnt;
        logic [7:0] cmd_byte;
        logic cmd_valid;
        logic cmd_last;
        // Error indication in progress.
        logic err_mode;
        logic [3:0] ecnt;
        logic [7:0] ecode;
        logic halted;
    } hphp_dev_st_t;
    hphp_dev_st_t st_ff, nxt_st;
    logic f_valid, f_ready, f_out_valid, f_pop;
    logic [7:0] f_data, f_out;

    // ==========================================================
    // Error indication bytes
    function automatic logic [7:0] fault_to_code(input hphp_pkg::hphp_fault_t f);
        unique case (f)
            hphp_pkg::FAULT_TASK_QUEUE: fault_to_code = `HPHP_ERR_TASK_QUEUE;
            hphp_pkg::FAULT_MEM_UNDERRUN: fault_to_code = `HPHP_ERR_MEM_UNDERRUN;
            hphp_pkg::FAULT_NET_QUEUE: fault_to_code = `HPHP_ERR_NET_QUEUE;
            hphp_pkg::FAULT_LINE_UNDERRUN: fault_to_code = `HPHP_ERR_LINE_UNDERRUN;
            hphp_pkg::FAULT_SERIAL_BUS: fault_to_code = `HPHP_ERR_SERIAL_BUS;
            default: fault_to_code = `HPHP_ERR_TASK_QUEUE;
        endcase
    endfunction

    // Byte of the error indication at a given position.
    function automatic logic [7:0] err_byte(input logic [3:0] idx, input logic [7:0] code);
        if (idx == 4'h0) begin
            err_byte = `HPHP_ERR_HEADER;
        end else if (idx == 4'h1) begin
            err_byte = code;
        end else begin
            err_byte = `HPHP_ERR_FILL;
        end
    endfunction

    // ==========================================================
    // Outbound queue
    // Firmware bytes queue here; an error indication replaces them.
    assign f_valid = ind_valid && !st_ff.err_mode;
    assign f_data = ind_byte;
    assign ind_ready = f_ready && !st_ff.err_mode;
    hphp_fifo #(
        .WIDTH(8),
        .DEPTH(DEPTH)
    ) hphp_fifo_i (
        .clk(clk),
        .nrst(nrst),
        .in_valid(f_valid),
        .in_ready(f_ready),
        .in_data(f_data),
        .out_valid(f_out_valid),
        .out_ready(f_pop),
        .out_data(f_out)
    );
    assign f_pop = !st_ff.err_mode && st_ff.avail && f_out_valid && !link.device_reset;

    // ==========================================================
    // Next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.cmd_valid = 1'b0;
        nxt_st.cmd_last = 1'b0;
        nxt_st.strobe_q = link.host_write_strobe;
        nxt_st.rack_q = link.host_read_ack;
        nxt_st.ack_q = st_ff.ack_pend;
        nxt_st.ack_pend = 1'b0;
        // An ack pulse wins over a latch write in the same cycle.
        if (st_ff.ack_q) begin
            nxt_st.wack = 1'b1;
        end else if (link.latch_write) begin
            nxt_st.wack = 1'b0;
        end
        // Device reset clears all but the FIFO and sets rst_seen, avail, strobe_q and rack_q; only nrst empties the FIFO.
        if (link.device_reset) begin
            nxt_st = '0;
            nxt_st.rst_seen = 1'b1;
            nxt_st.avail = 1'b1;
            nxt_st.strobe_q = 1'b1;
            nxt_st.rack_q = 1'b1;
        end else begin
            // The first edge out of device reset arms one ack pulse; the flag rises two
            // edges later, so the host never writes before the device runs.
            if (st_ff.rst_seen) begin
                nxt_st.rst_seen = 1'b0;
                nxt_st.ack_pend = 1'b1;
            end
            if (st_ff.strobe_q && !link.host_write_strobe && !st_ff.halted) begin
                nxt_st.cmd_byte = link.inbound_data_port;
                nxt_st.cmd_valid = 1'b1;
                nxt_st.cmd_last = st_ff.icnt == 4'(`HPHP_PRIM_BYTES - 1);
                nxt_st.icnt = nxt_st.cmd_last ? 4'h0 : st_ff.icnt + 4'h1;
                nxt_st.ack_pend = 1'b1;
            end
            // Outbound byte stands until the host read-ack rises again.
            // There is no timeout: a host that stops acknowledging stalls this
            // path for good, and only a device reset or nrst frees it.
            if (!st_ff.avail && !st_ff.rack_q && link.host_read_ack) begin
                nxt_st.avail = 1'b1;
            end else if (st_ff.avail && !st_ff.halted) begin
                if (st_ff.err_mode) begin
                    nxt_st.obyte = err_byte(st_ff.ecnt, st_ff.ecode);
                    nxt_st.avail = 1'b0;
                    nxt_st.ecnt = st_ff.ecnt + 4'h1;
                    // After the tenth byte the device stays silent until reset.
                    nxt_st.halted = st_ff.ecnt == 4'(`HPHP_PRIM_BYTES - 1);
                end else if (f_out_valid) begin
                    nxt_st.obyte = f_out;
                    nxt_st.avail = 1'b0;
                end
            end
            // Fault waits for any byte in flight, then takes over the path.
            if (fault_valid && !st_ff.err_mode) begin
                nxt_st.err_mode = 1'b1;
                nxt_st.ecode = fault_to_code(fault_code);
                nxt_st.ecnt = 4'h0;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            // Handshake lines leave reset at their idle levels.
            st_ff <= '0;
            st_ff.avail <= 1'b1;
            st_ff.strobe_q <= 1'b1;
            st_ff.rack_q <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // Outputs
    // Each output but ind_ready is a field of the state register.
    assign link.device_write_ack = st_ff.wack;
    assign link.byte_avail_to_host = st_ff.avail;
    assign link.outbound_data_port = st_ff.obyte;
    assign cmd_byte = st_ff.cmd_byte;
    assign cmd_valid = st_ff.cmd_valid;
    assign cmd_last = st_ff.cmd_last;
    assign halted = st_ff.halted;
endmodule

// *** design/hphp_host.sv ***
// Host end: sends ten-byte commands, collects ten-byte indications.
// Assumes user requests hold tx_valid with a byte until tx_ready is seen.
`timescale 1ns/1ps
`include "hphp_params.svh"
module hphp_host (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Link to device.
    hphp_if.host link,
    // User command path.
    input wire logic [7:0] tx_byte,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic dev_reset_req,
    // User indication path.
    output logic [7:0] rx_byte,
    output logic rx_valid,
    output logic rx_last,
    output logic err_seen
);
    typedef enum logic [2:0] {H_IDLE, H_WR, H_LOW, H_WAIT} hphp_tx_state_t;
    typedef enum logic [1:0] {R_IDLE, R_READ, R_LOW, R_HIGH} hphp_rx_state_t;
    typedef struct packed {
        hphp_tx_state_t ts;
        hphp_rx_state_t rs;
        logic [3:0] tcnt;
        logic [7:0] tdata;
        logic strobe;
        logic latch_wr;
        logic rack;
        logic oe;
        logic rst;
        logic avail_q;
        logic [3:0] rcnt;
        logic [7:0] rx_byte;
        logic rx_valid;
        logic rx_last;
        logic err;
    } hphp_host_st_t;
    hphp_host_st_t st_ff, nxt_st;
    always_comb begin
        nxt_st = st_ff;
        nxt_st.latch_wr = 1'b0;
        nxt_st.rx_valid = 1'b0;
        nxt_st.rx_last = 1'b0;
        nxt_st.rst = dev_reset_req;
        nxt_st.avail_q = link.byte_avail_to_host;
        unique case (st_ff.ts)
            H_IDLE: if (tx_valid && link.device_write_ack && !st_ff.rst && !st_ff.err) begin
                nxt_st.tdata = tx_byte;
                nxt_st.latch_wr = 1'b1;
                nxt_st.ts = H_WR;
            end
            H_WR: begin
                nxt_st.strobe = 1'b0;
                nxt_st.tcnt = 4'(`HPHP_STROBE_CYC);
                nxt_st.ts = H_LOW;
            end
            H_LOW: if (st_ff.tcnt == 4'h1) begin
                nxt_st.strobe = 1'b1;
                nxt_st.ts = H_WAIT;
            end else begin
                nxt_st.tcnt = st_ff.tcnt - 4'h1;
            end
            H_WAIT: nxt_st.ts = H_IDLE;
        endcase
        unique case (st_ff.rs)
            R_IDLE: if (st_ff.avail_q && !link.byte_avail_to_host) begin
                nxt_st.oe = 1'b1;
                nxt_st.rs = R_READ;
            end
            R_READ: begin
                nxt_st.rx_byte = link.host_bus;
                nxt_st.rx_valid = 1'b1;
                nxt_st.rx_last = st_ff.rcnt == 4'(`HPHP_PRIM_BYTES - 1);
                if (st_ff.rcnt == 4'h0 && link.host_bus == `HPHP_ERR_HEADER) begin
                    nxt_st.err = 1'b1;
                end
                nxt_st.rcnt = nxt_st.rx_last ? 4'h0 : st_ff.rcnt + 4'h1;
                nxt_st.oe = 1'b0;
                nxt_st.rack = 1'b0;
                nxt_st.rs = R_LOW;
            end
            R_LOW: begin
                nxt_st.rack = 1'b1;
                nxt_st.rs = R_HIGH;
            end
            R_HIGH: nxt_st.rs = R_IDLE;
        endcase
        if (st_ff.rst) begin
            nxt_st.ts = H_IDLE;
            nxt_st.rs = R_IDLE;
            nxt_st.rcnt = 4'h0;
            nxt_st.err = 1'b0;
            nxt_st.strobe = 1'b1;
            nxt_st.rack = 1'b1;
            nxt_st.oe = 1'b0;
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
            st_ff.strobe <= 1'b1;
            st_ff.rack <= 1'b1;
            st_ff.avail_q <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign link.host_write_strobe = st_ff.strobe;
    assign link.host_read_ack = st_ff.rack;
    assign link.device_reset = st_ff.rst;
    assign link.latch_write = st_ff.latch_wr;
    assign link.latch_data = st_ff.tdata;
    assign link.out_buf_oe = st_ff.oe;
    assign tx_ready = st_ff.ts == H_IDLE && link.device_write_ack && !st_ff.rst
        && !st_ff.err;
    assign rx_byte = st_ff.rx_byte;
    assign rx_valid = st_ff.rx_valid;
    assign rx_last = st_ff.rx_last;
    assign err_seen = st_ff.err;
endmodule

// *** test/hphp_link_sva.sv ***
// Checker for the handshake wires between the host and device ends.
// Assumes the bench instantiates it beside the interface and feeds it by name.
`timescale 1ns/1ps
module hphp_link_sva (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Handshake lines.
    input wire logic host_write_strobe,
    input wire logic device_write_ack,
    input wire logic byte_avail_to_host,
    input wire logic host_read_ack,
    input wire logic device_reset,
    input wire logic latch_write,
    // Data path.
    input wire logic [7:0] outbound_data_port,
    input wire logic out_buf_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // ==========================================================
    // Read acknowledge seen for the byte now on offer.
    logic ack_seen_ff;
    logic nxt_ack_seen;
    always_comb begin
        nxt_ack_seen = byte_avail_to_host ? 1'b0 : (ack_seen_ff | !host_read_ack);
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ack_seen_ff <= 1'b0;
        end else begin
            ack_seen_ff <= nxt_ack_seen;
        end
    end
    // ==========================================================
    // Properties.
    property p_latch_clears_ack;
        latch_write |=> !device_write_ack;
    endproperty
    a_latch_clears_ack: assert property (p_latch_clears_ack)
        else $error("write ack not cleared by latch write");
    property p_latch_needs_ack;
        latch_write |-> device_write_ack;
    endproperty
    a_latch_needs_ack: assert property (p_latch_needs_ack)
        else $error("latch written while write ack low");
    property p_strobe_pulse;
        $fell(host_write_strobe) |-> ##1 !host_write_strobe ##1 host_write_strobe;
    endproperty
    a_strobe_pulse: assert property (p_strobe_pulse)
        else $error("write strobe pulse has wrong length");
    property p_ack_after_byte;
        $fell(host_write_strobe) |-> !device_write_ack[*3] ##[1:4] device_write_ack;
    endproperty
    a_ack_after_byte: assert property (p_ack_after_byte)
        else $error("write ack not raised after byte read");
    property p_ack_after_reset;
        $fell(device_reset) |-> ##[1:4] device_write_ack;
    endproperty
    a_ack_after_reset: assert property (p_ack_after_reset)
        else $error("write ack not raised after device reset");
    property p_byte_holds;
        !byte_avail_to_host ##1 !byte_avail_to_host |-> $stable(outbound_data_port);
    endproperty
    a_byte_holds: assert property (p_byte_holds)
        else $error("outbound byte changed while on offer");
    property p_waits_for_ack;
        (!byte_avail_to_host && !ack_seen_ff && !device_reset) |=> !byte_avail_to_host;
    endproperty
    a_waits_for_ack: assert property (p_waits_for_ack)
        else $error("byte withdrawn before read ack");
    property p_oe_only_read;
        out_buf_oe |-> !byte_avail_to_host;
    endproperty
    a_oe_only_read: assert property (p_oe_only_read)
        else $error("outbound buffer enabled with no byte");
    property p_ack_pulse;
        $fell(host_read_ack) |-> !byte_avail_to_host ##1 host_read_ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("read ack pulse malformed");
endmodule

// *** test/host_primitive_handshake_port_tb.sv ***
// Bench joining host and device ends across the handshake interface.
// Assumes the design files and hphp_params.svh are compiled first.
`timescale 1ns/1ps
module host_primitive_handshake_port_tb;
    logic clk;
    logic nrst;
    logic [7:0] tx_byte;
    logic tx_valid;
    logic tx_ready;
    logic dev_reset_req;
    logic [7:0] rx_byte;
    logic rx_valid;
    logic rx_last;
    logic err_seen;
    logic [7:0] cmd_byte;
    logic cmd_valid;
    logic cmd_last;
    logic [7:0] ind_byte;
    logic ind_valid;
    logic ind_ready;
    logic fault_valid;
    hphp_pkg::hphp_fault_t fault_code;
    logic halted;
    logic [8:0] rx_q[$];
    logic [8:0] cmd_q[$];
    logic [7:0] codes [5] = '{8'h00, 8'h02, 8'h05, 8'h06, 8'h0b};
    int error_cnt = 0;
    int comparisons = 0;
    hphp_if lnk();
    hphp_device #(.DEPTH(8)) hphp_device_i (.clk(clk), .nrst(nrst), .link(lnk.device),
        .cmd_byte(cmd_byte), .cmd_valid(cmd_valid), .cmd_last(cmd_last), .ind_byte(ind_byte),
        .ind_valid(ind_valid), .ind_ready(ind_ready), .fault_valid(fault_valid),
        .fault_code(fault_code), .halted(halted));
    hphp_host hphp_host_i (.clk(clk), .nrst(nrst), .link(lnk.host), .tx_byte(tx_byte),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .dev_reset_req(dev_reset_req),
        .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_last(rx_last), .err_seen(err_seen));
    hphp_link_sva hphp_link_sva_i (.clk(clk), .nrst(nrst),
        .host_write_strobe(lnk.host_write_strobe), .device_write_ack(lnk.device_write_ack),
        .byte_avail_to_host(lnk.byte_avail_to_host), .host_read_ack(lnk.host_read_ack),
        .device_reset(lnk.device_reset), .latch_write(lnk.latch_write),
        .outbound_data_port(lnk.outbound_data_port), .out_buf_oe(lnk.out_buf_oe));
    // ==========================================================
    // Clock and collectors.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(negedge clk) begin
        if (rx_valid === 1'b1) rx_q.push_back({rx_last, rx_byte});
        if (cmd_valid === 1'b1) cmd_q.push_back({cmd_last, cmd_byte});
    end
    // ==========================================================
    // Shared tasks.
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask
    task automatic wait_n(input bit rx, input int n);
        int k;
        k = 0;
        while ((rx ? rx_q.size() : cmd_q.size()) < n && k < 2000) begin
            @(posedge clk);
            k++;
        end
        @(negedge clk);
        chk_bit(k < 2000, 1'b1);
    endtask
    task automatic tally_and_finish();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Scenarios.
    task automatic soft_reset();
        dev_reset_req <= 1'b1;
        repeat (4) @(posedge clk);
        dev_reset_req <= 1'b0;
        repeat (10) @(posedge clk);
        @(negedge clk);
        chk_bit(lnk.device_write_ack, 1'b1);
        chk_bit(lnk.byte_avail_to_host, 1'b1);
        chk_bit(lnk.host_write_strobe & lnk.host_read_ack, 1'b1);
        chk_bit(halted, 1'b0);
        chk_bit(err_seen, 1'b0);
        @(posedge clk);
    endtask
    task automatic send_cmd(input logic [7:0] base);
        int k;
        cmd_q.delete();
        for (int i = 0; i < 10; i++) begin
            tx_byte <= base + 8'(i);
            tx_valid <= 1'b1;
            k = 0;
            do begin
                @(negedge clk);
                k++;
            end while (tx_ready !== 1'b1 && k < 500);
            @(posedge clk);
        end
        tx_valid <= 1'b0;
        wait_n(1'b0, 10);
        for (int i = 0; i < 10; i++) begin
            chk_byte(cmd_q[i][7:0], base + 8'(i));
            chk_bit(cmd_q[i][8], i == 9);
        end
        @(posedge clk);
    endtask
    task automatic run_ind(input logic [7:0] base, input int n);
        int k;
        logic full;
        full = 1'b0;
        rx_q.delete();
        for (int i = 0; i < n; i++) begin
            ind_byte <= base + 8'(i);
            ind_valid <= 1'b1;
            k = 0;
            do begin
                @(negedge clk);
                k++;
            end while (ind_ready !== 1'b1 && k < 500);
            if (k > 1) full = 1'b1;
            @(posedge clk);
        end
        ind_valid <= 1'b0;
        wait_n(1'b1, n);
        for (int i = 0; i < n; i++) begin
            chk_byte(rx_q[i][7:0], base + 8'(i));
            chk_bit(rx_q[i][8], i % 10 == 9);
        end
        chk_bit(ind_ready, 1'b1);
        if (n > 10) chk_bit(full, 1'b1);
        @(posedge clk);
    endtask
    task automatic run_fault(input hphp_pkg::hphp_fault_t code, input logic [7:0] exp);
        soft_reset();
        rx_q.delete();
        fault_code <= code;
        fault_valid <= 1'b1;
        @(posedge clk);
        fault_valid <= 1'b0;
        wait_n(1'b1, 10);
        for (int i = 0; i < 10; i++) begin
            chk_byte(rx_q[i][7:0], i == 0 ? 8'h99 : (i == 1 ? exp : 8'h00));
        end
        chk_bit(rx_q[9][8], 1'b1);
        chk_bit(err_seen, 1'b1);
        chk_bit(halted, 1'b1);
        chk_bit(tx_ready, 1'b0);
        @(posedge clk);
    endtask
    // ==========================================================
    // Main sequence and watchdog.
    initial begin
        nrst = 1'b0;
        tx_byte = 8'h00;
        tx_valid = 1'b0;
        dev_reset_req = 1'b0;
        ind_byte = 8'h00;
        ind_valid = 1'b0;
        fault_valid = 1'b0;
        fault_code = hphp_pkg::FAULT_TASK_QUEUE;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        soft_reset();
        send_cmd(8'h20);
        run_ind(8'h40, 20);
        fork
            send_cmd(8'h60);
            run_ind(8'h80, 10);
        join
        for (int i = 0; i < 5; i++) begin
            run_fault(hphp_pkg::hphp_fault_t'(i), codes[i]);
        end
        soft_reset();
        send_cmd(8'ha0);
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        tally_and_finish();
    end
endmodule
